/* logic/psi_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module psi_decode
    import psi_pkg::*;
(
    // Address and image setup.
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_base,
    input wire logic [4:0] i_bs,
    input wire logic i_en,
    // Decode result.
    output logic o_hit
);
    // --------------------------------------------------------------
    // Compare mask
    // --------------------------------------------------------------
    // Ones on the address bits that are compared for this block size.
    function automatic logic [31:0] psi_cmp_mask(input logic [4:0] bs);
        psi_cmp_mask = 32'hffff_f000 << bs;
    endfunction : psi_cmp_mask

    // block size
    // Reserved codes never hit, so a bad setup cannot claim the whole space.
    always_comb begin
        o_hit = i_en && (i_bs <= PSI_BS_MAX)
            && (((i_addr ^ i_base) & psi_cmp_mask(i_bs)) == 32'h0000_0000);
    end
endmodule : psi_decode
`default_nettype wire

/* logic/psi_image.sv */
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module psi_image
    import psi_pkg::*;
#(
    parameter int IMAGE_INDEX = 0,
    parameter bit DUAL_PCI = 1'b1
) (
    // Clock and resets.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pci_rst_n,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // EEPROM preload.
    input wire logic i_eeprom_load,
    input wire logic [31:0] i_eeprom_ctl,
    // Processor bus request.
    input wire logic i_pb_valid,
    input wire logic [31:0] i_pb_addr,
    input wire logic i_pb_read,
    input wire logic [7:0] i_pb_bytes,
    input wire logic i_xfer_end,
    // Decision toward the fabric and PCI.
    output logic o_claim,
    output logic o_pci_start,
    output logic o_pci_io,
    output logic o_pci_bus2,
    output logic o_pci_burst,
    output logic [7:0] o_pci_bytes,
    output logic o_buf_hit,
    output logic o_tea,
    output logic [1:0] o_endian,
    output logic o_irq
);
    // Only eight images exist; refuse any other index at elaboration.
    if (IMAGE_INDEX < 0 || IMAGE_INDEX > 7) begin : g_bad_index
        $error("IMAGE_INDEX out of range");
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [31:0] ctl_q, ctl_d, base_q, base_d, misc_q, misc_d;
    logic [PSI_NIRQ-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [1:0] end_q, end_d;
    logic [31:0] rdata_d;
    logic ld;
    logic hit, keep_eff, mode, short_rd, oversize, seq;
    logic kept_q, kept_d;
    logic [31:0] next_q, next_d;
    logic claim_d, start_d, io_d, bus2_d, burst_d, bufh_d, tea_d;
    logic [7:0] bytes_d;

    assign ld = i_eeprom_load && (IMAGE_INDEX == 0);

    // Prefetch amount to bytes; reserved codes fall back to the minimum.
    function automatic logic [7:0] psi_fetch(input logic [2:0] amt);
        psi_fetch = (amt <= PSI_AMT_MAX) ? (PSI_MIN_FETCH << amt) : PSI_MIN_FETCH;
    endfunction : psi_fetch

    // Register writes, preload and write-one-to-clear status.
    always_comb begin
        ctl_d = ctl_q;
        base_d = base_q;
        misc_d = misc_q;
        mask_d = mask_q;
        end_d = end_q;
        if (ld) begin
            ctl_d = i_eeprom_ctl & PSI_CTL_WMASK;
            end_d = i_eeprom_ctl[PSI_B_END +: 2];
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                PSI_OFS_CTL: begin
                    ctl_d = i_reg_wdata & PSI_CTL_WMASK;
                    end_d = i_reg_wdata[PSI_B_END +: 2];
                end
                PSI_OFS_BASE: base_d = {i_reg_wdata[31:PSI_PAGE_BITS], 12'h000};
                PSI_OFS_MISC: misc_d = {30'h0, i_reg_wdata[1:0]};
                PSI_OFS_MASK: mask_d = i_reg_wdata[PSI_NIRQ-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle.
        stat_d = stat_q;
        if (i_reg_wr && i_reg_addr == PSI_OFS_STAT) begin
            stat_d = stat_q & ~i_reg_wdata[PSI_NIRQ-1:0];
        end
        stat_d = stat_d | ev;
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_reg_rd) begin
            case (i_reg_addr)
                PSI_OFS_CTL: rdata_d = ctl_q | {25'h0, end_q, 5'h00};
                PSI_OFS_BASE: rdata_d = base_q;
                PSI_OFS_MISC: rdata_d = misc_q;
                PSI_OFS_STAT: rdata_d = {29'h0, stat_q};
                PSI_OFS_MASK: rdata_d = {29'h0, mask_q};
                PSI_OFS_STATE: rdata_d = {next_q[31:1], kept_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Processor bus reset covers everything but the endian field.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_q <= PSI_CTL_RST;
            base_q <= 32'h0000_0000;
            misc_q <= PSI_MISC_RST;
            stat_q <= '0;
            mask_q <= '0;
            o_reg_rdata <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            base_q <= base_d;
            misc_q <= misc_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            o_reg_rdata <= rdata_d;
            o_irq <= |(stat_d & mask_d);
        end
    end

    // endian reset
    // The endian field follows the primary PCI reset instead.
    always_ff @(posedge i_clk or negedge i_pci_rst_n) begin
        if (!i_pci_rst_n) begin
            end_q <= PSI_END_RST;
            o_endian <= PSI_END_RST;
        end else begin
            end_q <= end_d;
            o_endian <= end_d;
        end
    end

    // --------------------------------------------------------------
    // Transaction decision
    // --------------------------------------------------------------
    psi_decode u_dec (
        .i_addr(i_pb_addr),
        .i_base(base_q),
        .i_bs(ctl_q[PSI_B_BS +: 5]),
        .i_en(ctl_q[PSI_B_IMG_EN]),
        .o_hit(hit)
    );

    assign mode = ctl_q[PSI_B_MODE];
    assign short_rd = ctl_q[PSI_B_MEM_IO];
    assign keep_eff = ctl_q[PSI_B_KEEP] && misc_q[PSI_B_ARTRY] && !mode;
    assign oversize = mode && !short_rd && (i_pb_bytes > PSI_IO_MAX);
    assign seq = kept_q && (i_pb_addr == next_q);

    // Command choice and prefetch tracking for one request.
    always_comb begin
        claim_d = 1'b0;
        start_d = 1'b0;
        io_d = 1'b0;
        burst_d = 1'b0;
        bufh_d = 1'b0;
        tea_d = 1'b0;
        bytes_d = 8'h00;
        bus2_d = DUAL_PCI && ctl_q[PSI_B_DESTINATION_SELECT];
        kept_d = kept_q;
        next_d = next_q;
        ev = '0;
        if (i_xfer_end && !keep_eff) begin
            kept_d = 1'b0;
        end
        if (i_pb_valid && i_pb_read && kept_q && !seq) begin
            kept_d = 1'b0;
            ev[PSI_I_DROP] = 1'b1;
        end
        if (i_pb_valid && hit) begin
            claim_d = 1'b1;
            if (oversize) begin
                tea_d = !misc_q[PSI_B_ERROR_ACK_ENABLE];
                ev[PSI_I_TEA] = 1'b1;
            end else if (i_pb_read && keep_eff && seq) begin
                bufh_d = 1'b1;
                next_d = i_pb_addr + {24'h0, i_pb_bytes};
                ev[PSI_I_HIT] = 1'b1;
            end else begin
                start_d = 1'b1;
                io_d = mode && !short_rd;
                burst_d = !mode;
                if (mode && i_pb_read && (i_pb_bytes > PSI_IO_MAX)) begin
                    // at most four
                    // Short memory reads ask for no more than four bytes.
                    bytes_d = PSI_IO_MAX;
                end else if (!i_pb_read || mode) begin
                    bytes_d = i_pb_bytes;
                end else begin
                    bytes_d = psi_fetch(ctl_q[PSI_B_AMT +: 3]);
                end
                if (i_pb_read && keep_eff) begin
                    kept_d = 1'b1;
                    next_d = i_pb_addr + {24'h0, i_pb_bytes};
                end
            end
        end
    end

    // Registered outputs; every decision shows one cycle after the request.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kept_q <= 1'b0;
            next_q <= 32'h0000_0000;
            o_claim <= 1'b0;
            o_pci_start <= 1'b0;
            o_pci_io <= 1'b0;
            o_pci_bus2 <= 1'b0;
            o_pci_burst <= 1'b0;
            o_pci_bytes <= 8'h00;
            o_buf_hit <= 1'b0;
            o_tea <= 1'b0;
        end else begin
            kept_q <= kept_d;
            next_q <= next_d;
            o_claim <= claim_d;
            o_pci_start <= start_d;
            o_pci_io <= io_d;
            o_pci_bus2 <= bus2_d;
            o_pci_burst <= burst_d;
            o_pci_bytes <= bytes_d;
            o_buf_hit <= bufh_d;
            o_tea <= tea_d;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_pci_rst_n);

    chk_buf_no_fetch: assert property (
        o_buf_hit |-> !o_pci_start && $past(seq) && $past(keep_eff))
        else $error("buffer hit without keep or with a fetch");
    chk_drop_mismatch: assert property (
        (i_pb_valid && i_pb_read && kept_q && !seq) |=> !kept_q || $past(start_d))
        else $error("kept data survived a mismatched read");
    chk_end_purge: assert property (
        (i_xfer_end && !keep_eff && !(i_pb_valid && hit)) |=> !kept_q)
        else $error("prefetch data kept past transfer end");
    chk_keep_gate: assert property (
        !misc_q[PSI_B_ARTRY] ##1 !misc_q[PSI_B_ARTRY] |-> !o_buf_hit)
        else $error("buffer served with retry disabled");
    chk_io_tea: assert property (
        (i_pb_valid && hit && oversize && !misc_q[PSI_B_ERROR_ACK_ENABLE]) |=> o_tea && !o_pci_start)
        else $error("oversize I/O not refused");
    chk_tea_quiet: assert property (
        (i_pb_valid && misc_q[PSI_B_ERROR_ACK_ENABLE]) |=> !o_tea)
        else $error("error acknowledge not suppressed");
    chk_io_size: assert property (
        (o_pci_start && o_pci_io) |-> o_pci_bytes <= PSI_IO_MAX && !o_pci_burst)
        else $error("I/O access over four bytes");
    chk_mode1_read: assert property (
        (i_pb_valid && hit && mode && i_pb_read) |=> o_pci_bytes <= PSI_IO_MAX)
        else $error("mode 1 read over four bytes");
    chk_mem_min: assert property (
        (o_pci_start && o_pci_burst && $past(i_pb_read)) |-> o_pci_bytes >= PSI_MIN_FETCH)
        else $error("memory read under eight bytes");
    chk_destination_select_bus: assert property (
        o_pci_start |-> o_pci_bus2 == (DUAL_PCI && $past(ctl_q[PSI_B_DESTINATION_SELECT])))
        else $error("wrong destination bus");
    chk_irq_level: assert property (
        ##1 o_irq == |$past(stat_d & mask_d))
        else $error("interrupt does not follow status");

    cov_buf_hit: cover property (o_pci_start ##[1:8] o_buf_hit);
    cov_tea: cover property (o_tea);
    cov_drop: cover property (ev[PSI_I_DROP]);
endmodule : psi_image
`default_nettype wire

/* logic/psi_pkg.sv */
package psi_pkg;
    // Register offsets on the plain register port.
    localparam logic [7:0] PSI_OFS_CTL = 8'h00;
    localparam logic [7:0] PSI_OFS_BASE = 8'h04;
    localparam logic [7:0] PSI_OFS_MISC = 8'h08;
    localparam logic [7:0] PSI_OFS_STAT = 8'h0c;
    localparam logic [7:0] PSI_OFS_MASK = 8'h10;
    localparam logic [7:0] PSI_OFS_STATE = 8'h14;
    // Field positions in slave_image_control.
    localparam int PSI_B_IMG_EN = 31;
    localparam int PSI_B_TA_EN = 30;
    localparam int PSI_B_MD_EN = 29;
    localparam int PSI_B_BS = 24;
    localparam int PSI_B_MODE = 23;
    localparam int PSI_B_DESTINATION_SELECT = 22;
    localparam int PSI_B_MEM_IO = 21;
    localparam int PSI_B_KEEP = 7;
    localparam int PSI_B_END = 5;
    localparam int PSI_B_AMT = 0;
    // Writable bits of slave_image_control, endian field excluded.
    localparam logic [31:0] PSI_CTL_WMASK = 32'hffe0_0087;
    localparam logic [31:0] PSI_END_WMASK = 32'h0000_0060;
    // Misc control bits.
    localparam int PSI_B_ARTRY = 0;
    localparam int PSI_B_ERROR_ACK_ENABLE = 1;
    // Reset values.
    localparam logic [31:0] PSI_CTL_RST = 32'h0000_0000;
    localparam logic [1:0] PSI_END_RST = 2'h2;
    localparam logic [31:0] PSI_MISC_RST = 32'h0000_0000;
    // Block size and prefetch limits.
    localparam logic [4:0] PSI_BS_MAX = 5'h13;
    localparam logic [2:0] PSI_AMT_MAX = 3'h4;
    localparam int PSI_PAGE_BITS = 12;
    localparam logic [7:0] PSI_MIN_FETCH = 8'h08;
    localparam logic [7:0] PSI_IO_MAX = 8'h04;
    // Interrupt status bits.
    localparam int PSI_I_TEA = 0;
    localparam int PSI_I_HIT = 1;
    localparam int PSI_I_DROP = 2;
    localparam int PSI_NIRQ = 3;
endpackage : psi_pkg

/* test/pb_to_pci_slave_image_cfg_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pb_to_pci_slave_image_cfg_tb_top;
    import psi_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [31:0] ADR = 32'h1234_5100;
    logic clk, rst_n, prst_n, wr, rd, eload, xend;
    logic [7:0] raddr;
    logic [31:0] wdata, ectl, rdata;
    logic pv, prd, claim, start, io, bus2, burst, bhit, tea, irq;
    logic [31:0] pa;
    logic [7:0] pn, pbytes;
    logic [1:0] endian;
    int n_mismatch = 0;
    int check_count = 0;

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    psi_image psi_image_i (.i_clk(clk), .i_rst_n(rst_n), .i_pci_rst_n(prst_n),
        .i_reg_addr(raddr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_eeprom_load(eload), .i_eeprom_ctl(ectl),
        .i_pb_valid(pv), .i_pb_addr(pa), .i_pb_read(prd), .i_pb_bytes(pn),
        .i_xfer_end(xend), .o_claim(claim), .o_pci_start(start), .o_pci_io(io),
        .o_pci_bus2(bus2), .o_pci_burst(burst), .o_pci_bytes(pbytes), .o_buf_hit(bhit),
        .o_tea(tea), .o_endian(endian), .o_irq(irq));
    psi_pb_master psi_pb_master_i (.i_clk(clk), .o_valid(pv), .o_addr(pa), .o_read(prd),
        .o_bytes(pn));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        raddr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        raddr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("register", e, rdata);
    endtask : rreg

    // Expected flags are claim, start, buffer hit, error ack.
    task automatic rq(input logic [31:0] a, input logic [7:0] n, input logic [3:0] e,
                      input logic eio, input logic [7:0] eb);
        psi_pb_master_i.issue(a, 1'b1, n);
        #1;
        chk("request flags", e, {claim, start, bhit, tea});
        if (e[2]) begin
            chk("io command", eio, io);
            chk("fetch bytes", eb, pbytes);
        end
    endtask : rq

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // A hang counts as a mismatch and still ends in the report.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        prst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        eload = 1'b0;
        xend = 1'b0;
        raddr = 8'h00;
        wdata = 32'h0;
        ectl = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        prst_n <= 1'b1;
        rreg(PSI_OFS_CTL, 32'h0000_0040);
        chk("endian", 2'b10, endian);
        rreg(PSI_OFS_MISC, 32'h0);
        rreg(8'h18, 32'h0);
        // Keep with retry enable, 32-byte prefetch.
        wreg(PSI_OFS_MISC, 32'h1);
        wreg(PSI_OFS_BASE, 32'h1234_5000);
        wreg(PSI_OFS_CTL, 32'h8000_00c2);
        rreg(PSI_OFS_CTL, 32'h8000_00c2);
        rq(32'h1234_6100, 8'd8, 4'b0000, 1'b0, 8'd0);
        rq(ADR, 8'd8, 4'b1100, 1'b0, 8'd32);
        chk("burst", 1'b1, burst);
        rq(ADR + 8, 8'd8, 4'b1010, 1'b0, 8'd0);
        rq(ADR + 16, 8'd8, 4'b1010, 1'b0, 8'd0);
        rq(ADR + 40, 8'd8, 4'b1100, 1'b0, 8'd32);
        rq(ADR + 24, 8'd8, 4'b1100, 1'b0, 8'd32);
        rreg(PSI_OFS_STAT, 32'h6);
        wreg(PSI_OFS_STAT, 32'h7);
        rreg(PSI_OFS_STAT, 32'h0);
        // Without retry enable nothing is kept.
        wreg(PSI_OFS_MISC, 32'h0);
        rq(ADR, 8'd8, 4'b1100, 1'b0, 8'd32);
        rq(ADR + 8, 8'd8, 4'b1100, 1'b0, 8'd32);
        // Every prefetch code, keep off; reserved codes fall back to 8 bytes.
        wreg(PSI_OFS_MISC, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wreg(PSI_OFS_CTL, 32'h8000_0040 | c);
            rq(ADR, 8'd8, 4'b1100, 1'b0, (c < 5) ? (8'h08 << c) : 8'h08);
            @(posedge clk);
            xend <= 1'b1;
            @(posedge clk);
            xend <= 1'b0;
            rq(ADR + 8, 8'd8, 4'b1100, 1'b0, (c < 5) ? (8'h08 << c) : 8'h08);
        end
        // Block size codes at the edges of the table.
        wreg(PSI_OFS_CTL, 32'h8100_0040);
        rq(32'h1234_4100, 8'd8, 4'b1100, 1'b0, 8'd8);
        wreg(PSI_OFS_CTL, 32'h8000_0040);
        rq(32'h1234_4100, 8'd8, 4'b0000, 1'b0, 8'd0);
        wreg(PSI_OFS_CTL, 32'h9300_0040);
        rq(32'h7fff_0000, 8'd8, 4'b1100, 1'b0, 8'd8);
        wreg(PSI_OFS_CTL, 32'h9400_0040);
        rq(ADR, 8'd8, 4'b0000, 1'b0, 8'd0);
        wreg(PSI_OFS_CTL, 32'h0000_0040);
        rq(ADR, 8'd8, 4'b0000, 1'b0, 8'd0);
        // I/O mode, oversize error and its interrupt.
        wreg(PSI_OFS_CTL, 32'h8080_00c4);
        wreg(PSI_OFS_MASK, 32'h1);
        rq(ADR, 8'd4, 4'b1100, 1'b1, 8'd4);
        rq(ADR + 4, 8'd4, 4'b1100, 1'b1, 8'd4);
        rq(ADR, 8'd8, 4'b1001, 1'b1, 8'd0);
        // The discard bit from the retry-off reads is still set beside the error bit.
        rreg(PSI_OFS_STAT, 32'h5);
        chk("irq", 1'b1, irq);
        wreg(PSI_OFS_STAT, 32'h1);
        rreg(PSI_OFS_STAT, 32'h4);
        chk("irq", 1'b0, irq);
        wreg(PSI_OFS_MISC, 32'h3);
        rq(ADR, 8'd8, 4'b1000, 1'b1, 8'd0);
        wreg(PSI_OFS_CTL, 32'h80a0_0040);
        rq(ADR, 8'd2, 4'b1100, 1'b0, 8'd2);
        rq(ADR, 8'd8, 4'b1100, 1'b0, 8'd4);
        wreg(PSI_OFS_CTL, 32'h8040_0040);
        rq(ADR, 8'd8, 4'b1100, 1'b0, 8'd8);
        chk("second bus", 1'b1, bus2);
        // Preload, then the two resets split the endian field from the rest.
        @(posedge clk);
        ectl <= 32'h8000_0020;
        eload <= 1'b1;
        @(posedge clk);
        eload <= 1'b0;
        rreg(PSI_OFS_CTL, 32'h8000_0020);
        chk("endian", 2'b01, endian);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rreg(PSI_OFS_CTL, 32'h0000_0020);
        @(posedge clk);
        prst_n <= 1'b0;
        repeat (2) @(posedge clk);
        prst_n <= 1'b1;
        #1;
        chk("endian", 2'b10, endian);
        test_done();
    end
endmodule : pb_to_pci_slave_image_cfg_tb_top
`default_nettype wire

/* test/psi_pb_master.sv */
`timescale 1ns/1ps
`default_nettype none
module psi_pb_master (
    // Clock.
    input wire logic i_clk,
    // Request toward the image.
    output logic o_valid,
    output logic [31:0] o_addr,
    output logic o_read,
    output logic [7:0] o_bytes
);
    // Idle lines show the inverse of the last request, never a stale copy.
    initial begin
        o_valid = 1'b0;
        o_addr = 32'h0;
        o_read = 1'b0;
        o_bytes = 8'h0;
    end

    // One request per call; the bench changes image setup only between calls.
    // settings stay still
    task automatic issue(input logic [31:0] a, input logic r, input logic [7:0] n);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_addr <= a;
        o_read <= r;
        o_bytes <= n;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_addr <= ~a;
        o_read <= ~r;
        o_bytes <= ~n;
    endtask : issue
endmodule : psi_pb_master
`default_nettype wire
